// file: pscp_pkg.sv
// Package of constants and types for the configuration intake port
package pscp_pkg;

	// Register byte offsets
	localparam logic [7:0] CTRL_OFFS     = 8'h00;
	localparam logic [7:0] BOOT_OFFS     = 8'h04;
	localparam logic [7:0] STATUS_OFFS   = 8'h08;
	localparam logic [7:0] COUNT_OFFS    = 8'h0C;
	localparam logic [7:0] EXPECT_OFFS   = 8'h10;

	// Control field positions
	localparam int CTRL_MODE_LSB  = 0;
	localparam int CTRL_BOOTLD    = 2;
	localparam int CTRL_DATA0_USR = 3;

	// Reset values
	localparam logic [23:0] BOOT_ADDR_RST = 24'h01_0000;
	localparam logic [31:0] EXPECT_RST    = 32'h0000_0100;
	localparam logic [1:0]  MODE_RST      = 2'h0;

	// Restart minimum low time and cycles at 25 MHz
	localparam int RESTART_MIN_NS  = 500;
	localparam int CLK_PERIOD_NS   = 40;
	localparam int RESTART_CYCLES  = (RESTART_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Configuration scheme
	typedef enum logic [1:0]
	{
		MODE_AP,
		MODE_PS,
		MODE_FPP
	} pscp_mode_e;

	// Load progress
	typedef enum logic [1:0]
	{
		ST_IDLE,
		ST_LOAD,
		ST_WAIT_DONE,
		ST_USER
	} pscp_state_e;

	// Flash master outputs
	typedef struct packed
	{
		logic [23:0] addr;
		logic        ce_n;
		logic        oe_n;
		logic        avd_n;
	} pscp_flash_s;

endpackage

// file: pscp_config_port.sv
// Configuration data intake port with AXI4-Lite control
// What this block does
// - In active parallel loading the flash wait signal is ignored.
// - Flash ownership needs the chain enable input low, active parallel mode and loading under way.
// - Active parallel fetch starts at word address 0x010000, replaceable by instruction.
// - Passive serial: one bit captured per rising configuration clock edge.
// - Fast passive parallel: one byte accepted per configuration clock cycle.
// - Clock may stop indefinitely; loading resumes without loss.
// - Serial data pin driven in user mode only when the control DATA0 user bit is set, in any mode.
// - A loaded device drives its chain enable output low.
// - Next device accepts data within three system clock cycles of being enabled.
// - Release load complete line when loaded; initialise only when line is high.
//
// Chosen here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module pscp_config_port
#(
	parameter int DATA_W = 8
)
(
	// System clock and reset
	input  wire logic              CLK_IN,
	input  wire logic              SRST_IN,
	// AXI4-Lite slave
	input  wire logic [7:0]        S_AXI_AWADDR_IN,
	input  wire logic              S_AXI_AWVALID_IN,
	output logic                   S_AXI_AWREADY_OUT,
	input  wire logic [31:0]       S_AXI_WDATA_IN,
	input  wire logic [3:0]        S_AXI_WSTRB_IN,
	input  wire logic              S_AXI_WVALID_IN,
	output logic                   S_AXI_WREADY_OUT,
	output logic [1:0]             S_AXI_BRESP_OUT,
	output logic                   S_AXI_BVALID_OUT,
	input  wire logic              S_AXI_BREADY_IN,
	input  wire logic [7:0]        S_AXI_ARADDR_IN,
	input  wire logic              S_AXI_ARVALID_IN,
	output logic                   S_AXI_ARREADY_OUT,
	output logic [31:0]            S_AXI_RDATA_OUT,
	output logic [1:0]             S_AXI_RRESP_OUT,
	output logic                   S_AXI_RVALID_OUT,
	input  wire logic              S_AXI_RREADY_IN,
	// Link clock domain
	input  wire logic              CONFIG_CLOCK_IN,
	input  wire logic [DATA_W-1:0] CONFIG_DATA_IN,
	// Control pins
	input  wire logic              CONFIG_RESTART_N_IN,
	input  wire logic              CHAIN_ENABLE_N_IN,
	input  wire logic              FLASH_WAIT_IN,
	output logic                   CHAIN_ENABLE_N_OUT,
	// Open-drain load complete line
	input  wire logic              LOAD_COMPLETE_IN,
	output logic                   LOAD_COMPLETE_OUT,
	output logic                   LOAD_COMPLETE_OE_OUT,
	output logic                   INIT_START_OUT,
	// Serial data pin drive in user mode
	output logic                   DATA0_OUT,
	output logic                   DATA0_OE_OUT,
	// Flash master
	output pscp_pkg::pscp_flash_s  FLASH_OUT,
	output logic                   FLASH_BUS_OWNED_OUT
);

	// ************************************************************
	// Pin synchronisers
	// ************************************************************

	logic [1:0] restart_sync_reg;
	logic [1:0] chain_sync_reg;
	logic [1:0] done_sync_reg;
	logic [1:0] wait_sync_reg;
	logic       restart_n;
	logic       chain_n;
	logic       line_high;

	// Two stages per pin; the flash wait level only reaches status, never loading
	always_ff @(posedge CLK_IN)
	begin
		if (SRST_IN)
		begin
			restart_sync_reg <= 2'h0;
			chain_sync_reg   <= 2'h3;
			done_sync_reg    <= 2'h0;
			wait_sync_reg    <= 2'h0;
		end
		else
		begin
			restart_sync_reg <= {restart_sync_reg[0], CONFIG_RESTART_N_IN};
			chain_sync_reg   <= {chain_sync_reg[0], CHAIN_ENABLE_N_IN};
			done_sync_reg    <= {done_sync_reg[0], LOAD_COMPLETE_IN};
			wait_sync_reg    <= {wait_sync_reg[0], FLASH_WAIT_IN};
		end
	end

	assign restart_n = restart_sync_reg[1];
	assign chain_n   = chain_sync_reg[1];
	assign line_high = done_sync_reg[1];

	// ************************************************************
	// Registers
	// ************************************************************

	logic [1:0]  mode_reg;
	logic [23:0] boot_addr_reg;
	logic        boot_load_reg;
	logic        data0_user_reg;
	logic [31:0] expect_reg;
	logic        aw_got_reg;
	logic        w_got_reg;
	logic [7:0]  aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0]  w_strb_reg;
	logic        wr_do;
	logic [31:0] ctrl_wval;
	logic [31:0] rd_val;
	logic        rd_hit;

	// Write address and data captured independently; readys are registered
	always_ff @(posedge CLK_IN)
	begin
		if (SRST_IN)
		begin
			aw_got_reg        <= 1'b0;
			w_got_reg         <= 1'b0;
			aw_addr_reg       <= 8'h00;
			w_data_reg        <= 32'h0000_0000;
			w_strb_reg        <= 4'h0;
			S_AXI_AWREADY_OUT <= 1'b0;
			S_AXI_WREADY_OUT  <= 1'b0;
		end
		else
		begin
			if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT)
			begin
				aw_got_reg        <= 1'b1;
				aw_addr_reg       <= S_AXI_AWADDR_IN;
				S_AXI_AWREADY_OUT <= 1'b0;
			end
			else
			begin
				if (wr_do)
					aw_got_reg <= 1'b0;
				// Reopens only once the previous response has gone
				S_AXI_AWREADY_OUT <= !aw_got_reg && !S_AXI_BVALID_OUT;
			end
			if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT)
			begin
				w_got_reg        <= 1'b1;
				w_data_reg       <= S_AXI_WDATA_IN;
				w_strb_reg       <= S_AXI_WSTRB_IN;
				S_AXI_WREADY_OUT <= 1'b0;
			end
			else
			begin
				if (wr_do)
					w_got_reg <= 1'b0;
				S_AXI_WREADY_OUT <= !w_got_reg && !S_AXI_BVALID_OUT;
			end
		end
	end

	assign wr_do = aw_got_reg && w_got_reg && !S_AXI_BVALID_OUT;

	// Write response one cycle after both halves held
	always_ff @(posedge CLK_IN)
	begin
		if (SRST_IN)
		begin
			S_AXI_BVALID_OUT <= 1'b0;
			S_AXI_BRESP_OUT  <= pscp_pkg::RESP_OKAY;
		end
		else if (wr_do)
		begin
			S_AXI_BVALID_OUT <= 1'b1;
			S_AXI_BRESP_OUT  <= (aw_addr_reg[7:2] <= pscp_pkg::EXPECT_OFFS[7:2])
				? pscp_pkg::RESP_OKAY : pscp_pkg::RESP_SLVERR;
		end
		else if (S_AXI_BREADY_IN)
			S_AXI_BVALID_OUT <= 1'b0;
	end

	assign ctrl_wval = w_data_reg;

	// Software controlled settings, low byte lane holds control
	always_ff @(posedge CLK_IN)
	begin
		if (SRST_IN)
		begin
			mode_reg       <= pscp_pkg::MODE_RST;
			boot_addr_reg  <= pscp_pkg::BOOT_ADDR_RST;
			boot_load_reg  <= 1'b0;
			data0_user_reg <= 1'b0;
			expect_reg     <= pscp_pkg::EXPECT_RST;
		end
		else
		begin
			boot_load_reg <= 1'b0;
			if (wr_do && aw_addr_reg == pscp_pkg::CTRL_OFFS && w_strb_reg[0])
			begin
				mode_reg       <= ctrl_wval[pscp_pkg::CTRL_MODE_LSB +: 2];
				boot_load_reg  <= ctrl_wval[pscp_pkg::CTRL_BOOTLD];
				data0_user_reg <= ctrl_wval[pscp_pkg::CTRL_DATA0_USR];
			end
			// Stands in for the boundary-scan address instruction
			if (wr_do && aw_addr_reg == pscp_pkg::BOOT_OFFS)
			begin
				for (int i = 0; i < 3; i++)
					if (w_strb_reg[i])
						boot_addr_reg[i*8 +: 8] <= w_data_reg[i*8 +: 8];
			end
			if (wr_do && aw_addr_reg == pscp_pkg::EXPECT_OFFS)
			begin
				for (int i = 0; i < 4; i++)
					if (w_strb_reg[i])
						expect_reg[i*8 +: 8] <= w_data_reg[i*8 +: 8];
			end
		end
	end

	// ************************************************************
	// Link domain capture
	// ************************************************************

	logic              load_en_reg;
	logic [DATA_W-1:0] link_shift_reg;
	logic              link_tog_reg;
	logic [1:0]        mode_link_sync0_reg;
	logic [1:0]        mode_link_reg;

	// Mode carried to the link clock; software holds it still while loading
	always_ff @(posedge CONFIG_CLOCK_IN)
	begin
		mode_link_sync0_reg <= mode_reg;
		mode_link_reg       <= mode_link_sync0_reg;
	end

	// Cleared at once when loading stops, as the link clock may be halted
	// Hazard: the host keeps the link clock still as loading is being enabled
	always_ff @(posedge CONFIG_CLOCK_IN or negedge load_en_reg)
	begin
		if (!load_en_reg)
		begin
			link_tog_reg   <= 1'b0;
			link_shift_reg <= '0;
		end
		else if (mode_link_reg == 2'(pscp_pkg::MODE_PS))
		begin
			link_shift_reg <= {link_shift_reg[DATA_W-2:0], CONFIG_DATA_IN[0]};
			link_tog_reg   <= ~link_tog_reg;
		end
		else
		begin
			link_shift_reg <= CONFIG_DATA_IN;
			link_tog_reg   <= ~link_tog_reg;
		end
	end

	// ************************************************************
	// Load sequence in the system domain
	// ************************************************************

	pscp_pkg::pscp_state_e state_reg;
	logic [2:0]  tog_sync_reg;
	logic [31:0] bits_reg;
	logic [23:0] fetch_addr_reg;
	logic [7:0]  restart_cnt_reg;
	logic        tog_seen;

	assign tog_seen = tog_sync_reg[2] ^ tog_sync_reg[1];

	// Event toggle crossing; the bit count follows each toggle
	always_ff @(posedge CLK_IN)
	begin
		if (SRST_IN)
			tog_sync_reg <= 3'h0;
		else
			tog_sync_reg <= {tog_sync_reg[1:0], link_tog_reg};
	end

	// Restart low-time counter
	always_ff @(posedge CLK_IN)
	begin
		if (SRST_IN || restart_n)
			restart_cnt_reg <= 8'h00;
		else if (restart_cnt_reg < 8'(pscp_pkg::RESTART_CYCLES))
			restart_cnt_reg <= restart_cnt_reg + 8'h01;
	end

	// Main load state machine
	always_ff @(posedge CLK_IN)
	begin
		if (SRST_IN)
		begin
			state_reg      <= pscp_pkg::ST_IDLE;
			load_en_reg    <= 1'b0;
			bits_reg       <= 32'h0000_0000;
			fetch_addr_reg <= pscp_pkg::BOOT_ADDR_RST;
		end
		else if (!restart_n || chain_n)
		begin
			state_reg   <= pscp_pkg::ST_IDLE;
			load_en_reg <= 1'b0;
			bits_reg    <= 32'h0000_0000;
		end
		else
		begin
			unique case (state_reg)
				pscp_pkg::ST_IDLE:
				begin
					state_reg      <= pscp_pkg::ST_LOAD;
					load_en_reg    <= 1'b1;
					fetch_addr_reg <= boot_addr_reg;
				end
				pscp_pkg::ST_LOAD:
				begin
					if (tog_seen)
					begin
						bits_reg <= bits_reg + ((mode_reg == 2'(pscp_pkg::MODE_PS))
							? 32'h0000_0001 : 32'(DATA_W));
						if (mode_reg == 2'(pscp_pkg::MODE_AP))
							fetch_addr_reg <= fetch_addr_reg + 24'h00_0001;
					end
					// Software may restart the fetch at the set address
					if (boot_load_reg)
						fetch_addr_reg <= boot_addr_reg;
					if (bits_reg >= expect_reg)
					begin
						state_reg   <= pscp_pkg::ST_WAIT_DONE;
						load_en_reg <= 1'b0;
					end
				end
				pscp_pkg::ST_WAIT_DONE:
					if (line_high)
						state_reg <= pscp_pkg::ST_USER;
				pscp_pkg::ST_USER:
					state_reg <= pscp_pkg::ST_USER;
			endcase
		end
	end

	// ************************************************************
	// Pin outputs
	// ************************************************************

	// Chain, done line, serial pin and flash drive
	always_ff @(posedge CLK_IN)
	begin
		if (SRST_IN)
		begin
			CHAIN_ENABLE_N_OUT   <= 1'b1;
			LOAD_COMPLETE_OUT    <= 1'b0;
			LOAD_COMPLETE_OE_OUT <= 1'b1;
			INIT_START_OUT       <= 1'b0;
			DATA0_OUT            <= 1'b0;
			DATA0_OE_OUT         <= 1'b0;
			FLASH_OUT            <= '{addr: 24'h00_0000, ce_n: 1'b1, oe_n: 1'b1, avd_n: 1'b1};
			FLASH_BUS_OWNED_OUT  <= 1'b0;
		end
		else
		begin
			CHAIN_ENABLE_N_OUT   <= !(state_reg == pscp_pkg::ST_WAIT_DONE
				|| state_reg == pscp_pkg::ST_USER);
			LOAD_COMPLETE_OUT    <= 1'b0;
			LOAD_COMPLETE_OE_OUT <= (state_reg == pscp_pkg::ST_IDLE
				|| state_reg == pscp_pkg::ST_LOAD);
			INIT_START_OUT       <= (state_reg == pscp_pkg::ST_USER);
			DATA0_OUT            <= 1'b0;
			DATA0_OE_OUT         <= (state_reg == pscp_pkg::ST_USER) && data0_user_reg
				&& (mode_reg != 2'(pscp_pkg::MODE_FPP) || data0_user_reg);
			FLASH_BUS_OWNED_OUT  <= load_en_reg && mode_reg == 2'(pscp_pkg::MODE_AP);
			FLASH_OUT.addr  <= fetch_addr_reg;
			FLASH_OUT.ce_n  <= !(load_en_reg && mode_reg == 2'(pscp_pkg::MODE_AP));
			FLASH_OUT.oe_n  <= !(load_en_reg && mode_reg == 2'(pscp_pkg::MODE_AP));
			FLASH_OUT.avd_n <= !(load_en_reg && mode_reg == 2'(pscp_pkg::MODE_AP));
		end
	end

	// ************************************************************
	// Read channel
	// ************************************************************

	// Read mux of status and settings
	always_comb
	begin
		rd_hit = 1'b1;
		unique case (S_AXI_ARADDR_IN)
			pscp_pkg::CTRL_OFFS:   rd_val = {28'h000_0000, data0_user_reg, 1'b0, mode_reg};
			pscp_pkg::BOOT_OFFS:   rd_val = {8'h00, boot_addr_reg};
			pscp_pkg::STATUS_OFFS: rd_val = {24'h00_0000, restart_cnt_reg[7:4] == 4'h0
				&& restart_cnt_reg >= 8'(pscp_pkg::RESTART_CYCLES), line_high, chain_n,
				restart_n, wait_sync_reg[1], load_en_reg, 2'(state_reg)};
			pscp_pkg::COUNT_OFFS:  rd_val = bits_reg;
			pscp_pkg::EXPECT_OFFS: rd_val = expect_reg;
			default:
			begin
				rd_val = 32'h0000_0000;
				rd_hit = 1'b0;
			end
		endcase
	end

	// Read answer one cycle after address taken
	always_ff @(posedge CLK_IN)
	begin
		if (SRST_IN)
		begin
			S_AXI_ARREADY_OUT <= 1'b0;
			S_AXI_RVALID_OUT  <= 1'b0;
			S_AXI_RDATA_OUT   <= 32'h0000_0000;
			S_AXI_RRESP_OUT   <= pscp_pkg::RESP_OKAY;
		end
		else
		begin
			S_AXI_ARREADY_OUT <= !S_AXI_RVALID_OUT && !S_AXI_ARREADY_OUT && S_AXI_ARVALID_IN;
			if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT)
			begin
				S_AXI_RVALID_OUT <= 1'b1;
				S_AXI_RDATA_OUT  <= rd_val;
				S_AXI_RRESP_OUT  <= rd_hit ? pscp_pkg::RESP_OKAY : pscp_pkg::RESP_SLVERR;
			end
			else if (S_AXI_RREADY_IN)
				S_AXI_RVALID_OUT <= 1'b0;
		end
	end

endmodule

`default_nettype wire

// file: pscp_config_port_chk.sv
// Port checker of the configuration intake port
`timescale 1ns/1ps
`default_nettype none
module pscp_config_port_chk
(
	// Clock and reset
	input wire logic                  CLK_IN,
	input wire logic                  SRST_IN,
	// Bus answers
	input wire logic                  S_AXI_BVALID_OUT,
	input wire logic                  S_AXI_BREADY_IN,
	input wire logic                  S_AXI_RVALID_OUT,
	input wire logic                  S_AXI_RREADY_IN,
	// Configuration pins
	input wire logic                  CONFIG_RESTART_N_IN,
	input wire logic                  CHAIN_ENABLE_N_IN,
	input wire logic                  CHAIN_ENABLE_N_OUT,
	input wire logic                  LOAD_COMPLETE_IN,
	input wire logic                  LOAD_COMPLETE_OUT,
	input wire logic                  LOAD_COMPLETE_OE_OUT,
	input wire logic                  INIT_START_OUT,
	input wire logic                  DATA0_OE_OUT,
	input wire pscp_pkg::pscp_flash_s FLASH_OUT,
	input wire logic                  FLASH_BUS_OWNED_OUT
);
	// ****
	// Assertions
	// ****
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (SRST_IN);
	AST_HANDOFF: assert property ($fell(CHAIN_ENABLE_N_OUT) |-> ##[0:2] !LOAD_COMPLETE_OE_OUT)
		else $error("chain output fell without line release");
	AST_INIT_LINE: assert property ($rose(INIT_START_OUT) |-> $past(LOAD_COMPLETE_IN))
		else $error("init started while line low");
	AST_OPEN_DRAIN: assert property (LOAD_COMPLETE_OE_OUT |-> !LOAD_COMPLETE_OUT)
		else $error("line driven high");
	AST_DATA0_FLOAT: assert property (!INIT_START_OUT |-> !DATA0_OE_OUT)
		else $error("serial pin driven outside user mode");
	AST_RESTART_HOLD: assert property (!CONFIG_RESTART_N_IN [*6] |-> CHAIN_ENABLE_N_OUT
		&& LOAD_COMPLETE_OE_OUT && !INIT_START_OUT) else $error("restart low not obeyed");
	AST_CHAIN_RELEASE: assert property (CHAIN_ENABLE_N_IN [*6] |-> !FLASH_BUS_OWNED_OUT)
		else $error("flash kept while chain input high");
	AST_STROBES: assert property (!FLASH_BUS_OWNED_OUT |-> FLASH_OUT.ce_n && FLASH_OUT.oe_n)
		else $error("flash strobes active without ownership");
	AST_BONE: assert property (S_AXI_BVALID_OUT && S_AXI_BREADY_IN |=> !S_AXI_BVALID_OUT)
		else $error("write response repeated");
	AST_RONE: assert property (S_AXI_RVALID_OUT && S_AXI_RREADY_IN |=> !S_AXI_RVALID_OUT)
		else $error("read response repeated");
	// Main scenarios reached
	COV_INIT: cover property ($rose(INIT_START_OUT));
	COV_CHAIN: cover property ($fell(CHAIN_ENABLE_N_OUT));
	COV_TAKE: cover property (CHAIN_ENABLE_N_IN [*6] ##1 !CHAIN_ENABLE_N_IN);
endmodule
bind pscp_config_port pscp_config_port_chk u_chk
(
	.CLK_IN, .SRST_IN, .S_AXI_BVALID_OUT, .S_AXI_BREADY_IN, .S_AXI_RVALID_OUT,
	.S_AXI_RREADY_IN, .CONFIG_RESTART_N_IN, .CHAIN_ENABLE_N_IN, .CHAIN_ENABLE_N_OUT,
	.LOAD_COMPLETE_IN, .LOAD_COMPLETE_OUT, .LOAD_COMPLETE_OE_OUT, .INIT_START_OUT,
	.DATA0_OE_OUT, .FLASH_OUT, .FLASH_BUS_OWNED_OUT
);
`default_nettype wire

// file: pscp_host_model.sv
// Behavioural configuration host driving link clock and data
`timescale 1ns/1ps
`default_nettype none
module pscp_host_model
(
	// Link outputs
	output var logic       link_clk_out,
	output var logic [7:0] link_data_out
);
	// Idle: clock still, data at a fixed level
	initial
	begin
		link_clk_out = 1'h0;
		link_data_out = 8'h00;
	end
	// One unit per rising edge, set up half a period before
	task automatic send(input logic [7:0] d);
		link_data_out = d;
		#40 link_clk_out = 1'h1;
		#40 link_clk_out = 1'h0;
	endtask
	// Frame over: data back to the fixed level
	task automatic rest();
		#13 link_data_out = 8'h00;
	endtask
endmodule
`default_nettype wire

// file: pscp_config_port_test.sv
// Self-checking bench of the configuration intake port
`timescale 1ns/1ps
`default_nettype none
module pscp_config_port_test;
	// Bench signals
	logic        CLK_IN = 1'h0, SRST_IN = 1'h1, FLASH_WAIT_IN = 1'h0;
	logic        S_AXI_AWVALID_IN = 1'h0, S_AXI_WVALID_IN = 1'h0, S_AXI_BREADY_IN = 1'h0;
	logic        S_AXI_ARVALID_IN = 1'h0, S_AXI_RREADY_IN = 1'h0;
	logic        CONFIG_RESTART_N_IN = 1'h1, CHAIN_ENABLE_N_IN = 1'h0;
	logic [7:0]  S_AXI_AWADDR_IN = 8'h00, S_AXI_ARADDR_IN = 8'h00, CONFIG_DATA_IN;
	logic [31:0] S_AXI_WDATA_IN = 32'h0000_0000, S_AXI_RDATA_OUT, rd, boot;
	logic [3:0]  S_AXI_WSTRB_IN = 4'hf;
	logic        S_AXI_AWREADY_OUT, S_AXI_WREADY_OUT, S_AXI_BVALID_OUT, S_AXI_ARREADY_OUT;
	logic        S_AXI_RVALID_OUT, CONFIG_CLOCK_IN, CHAIN_ENABLE_N_OUT, LOAD_COMPLETE_IN;
	logic        LOAD_COMPLETE_OUT, LOAD_COMPLETE_OE_OUT, INIT_START_OUT, DATA0_OUT;
	logic        DATA0_OE_OUT, FLASH_BUS_OWNED_OUT;
	logic [1:0]  S_AXI_BRESP_OUT, S_AXI_RRESP_OUT, resp;
	int          failures = 0, comparisons = 0, cycles = 0;
	pscp_pkg::pscp_flash_s FLASH_OUT;
	// Clock, pulled-up line, random flash wait
	always #20 CLK_IN = ~CLK_IN;
	assign LOAD_COMPLETE_IN = !(LOAD_COMPLETE_OE_OUT && !LOAD_COMPLETE_OUT);
	always @(posedge CLK_IN) FLASH_WAIT_IN <= 1'($urandom);
	pscp_config_port #(.DATA_W(8)) DUT
	(
		.CLK_IN, .SRST_IN, .S_AXI_AWADDR_IN, .S_AXI_AWVALID_IN, .S_AXI_AWREADY_OUT,
		.S_AXI_WDATA_IN, .S_AXI_WSTRB_IN, .S_AXI_WVALID_IN, .S_AXI_WREADY_OUT,
		.S_AXI_BRESP_OUT, .S_AXI_BVALID_OUT, .S_AXI_BREADY_IN, .S_AXI_ARADDR_IN,
		.S_AXI_ARVALID_IN, .S_AXI_ARREADY_OUT, .S_AXI_RDATA_OUT, .S_AXI_RRESP_OUT,
		.S_AXI_RVALID_OUT, .S_AXI_RREADY_IN, .CONFIG_CLOCK_IN, .CONFIG_DATA_IN,
		.CONFIG_RESTART_N_IN, .CHAIN_ENABLE_N_IN, .FLASH_WAIT_IN, .CHAIN_ENABLE_N_OUT,
		.LOAD_COMPLETE_IN, .LOAD_COMPLETE_OUT, .LOAD_COMPLETE_OE_OUT, .INIT_START_OUT,
		.DATA0_OUT, .DATA0_OE_OUT, .FLASH_OUT, .FLASH_BUS_OWNED_OUT
	);
	pscp_host_model host (.link_clk_out(CONFIG_CLOCK_IN), .link_data_out(CONFIG_DATA_IN));
	// ****
	// Tasks
	// ****
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	function automatic logic [31:0] exp_bits(input pscp_pkg::pscp_mode_e m, input int n);
		return (m == pscp_pkg::MODE_PS) ? 32'(n) : 32'(n * 8);
	endfunction
	// Write: address and data together, each released when taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_hs, w_hs, b_hs;
		S_AXI_AWADDR_IN <= a;
		S_AXI_WDATA_IN <= d;
		S_AXI_AWVALID_IN <= 1'h1;
		S_AXI_WVALID_IN <= 1'h1;
		S_AXI_BREADY_IN <= 1'h1;
		do
		begin
			@(negedge CLK_IN);
			aw_hs = S_AXI_AWREADY_OUT && S_AXI_AWVALID_IN;
			w_hs = S_AXI_WREADY_OUT && S_AXI_WVALID_IN;
			b_hs = S_AXI_BVALID_OUT;
			resp = S_AXI_BRESP_OUT;
			@(posedge CLK_IN);
			if (aw_hs) S_AXI_AWVALID_IN <= 1'h0;
			if (w_hs) S_AXI_WVALID_IN <= 1'h0;
		end
		while (!b_hs);
		S_AXI_BREADY_IN <= 1'h0;
		@(posedge CLK_IN);
	endtask
	task automatic axi_rd(input logic [7:0] a);
		logic ar_hs, r_hs;
		S_AXI_ARADDR_IN <= a;
		S_AXI_ARVALID_IN <= 1'h1;
		S_AXI_RREADY_IN <= 1'h1;
		do
		begin
			@(negedge CLK_IN);
			ar_hs = S_AXI_ARREADY_OUT && S_AXI_ARVALID_IN;
			r_hs = S_AXI_RVALID_OUT;
			rd = S_AXI_RDATA_OUT;
			resp = S_AXI_RRESP_OUT;
			@(posedge CLK_IN);
			if (ar_hs) S_AXI_ARVALID_IN <= 1'h0;
		end
		while (!r_hs);
		S_AXI_RREADY_IN <= 1'h0;
		@(posedge CLK_IN);
	endtask
	// Mode and length set, restart held low past its minimum
	task automatic load_setup(input pscp_pkg::pscp_mode_e m, input logic [31:0] n);
		axi_wr(pscp_pkg::CTRL_OFFS, {30'h0, m});
		axi_wr(pscp_pkg::EXPECT_OFFS, n);
		CONFIG_RESTART_N_IN <= 1'h0;
		repeat (16) @(posedge CLK_IN);
		axi_rd(pscp_pkg::STATUS_OFFS);
		check("restart_min", rd[7], 1'h1);
		CONFIG_RESTART_N_IN <= 1'h1;
		repeat (6) @(negedge CLK_IN);
		check("owned", FLASH_BUS_OWNED_OUT, m == pscp_pkg::MODE_AP && !CHAIN_ENABLE_N_IN);
		@(posedge CLK_IN);
	endtask
	// Frame of random units, then the link clock stands still
	task automatic frame(input int n);
		#7;
		repeat (n) host.send(8'($urandom));
		host.rest();
		repeat (8) @(posedge CLK_IN);
	endtask
	task automatic count_is(input logic [31:0] exp);
		axi_rd(pscp_pkg::COUNT_OFFS);
		check("count", rd, exp);
	endtask
	// Wait for user mode, then the pins after loading
	task automatic end_pins();
		for (int i = 0; i < 60 && INIT_START_OUT !== 1'h1; i++)
			@(posedge CLK_IN);
		@(negedge CLK_IN);
		check("chain_out", CHAIN_ENABLE_N_OUT, 1'h0);
		check("line_oe", LOAD_COMPLETE_OE_OUT, 1'h0);
		check("init", INIT_START_OUT, 1'h1);
		check("data0_oe", DATA0_OE_OUT, 1'h0);
		@(posedge CLK_IN);
	endtask
	task automatic give_verdict();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Hang guard
	always @(posedge CLK_IN)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			failures++;
			give_verdict();
		end
	end
	// ****
	// Tests
	// ****
	initial
	begin
		void'($urandom(32'h4d50_6cf7));
		repeat (20) @(posedge CLK_IN);
		SRST_IN <= 1'h0;
		repeat (3) @(posedge CLK_IN);
		axi_rd(pscp_pkg::BOOT_OFFS);
		check("boot_rst", rd, {8'h00, pscp_pkg::BOOT_ADDR_RST});
		axi_rd(pscp_pkg::EXPECT_OFFS);
		check("expect_rst", rd, pscp_pkg::EXPECT_RST);
		axi_rd(8'h14);
		check("rd_unmapped", resp, pscp_pkg::RESP_SLVERR);
		axi_wr(8'h14, 32'h0000_0001);
		check("wr_unmapped", resp, pscp_pkg::RESP_SLVERR);
		boot = $urandom & 32'h00ff_ffff;
		axi_wr(pscp_pkg::BOOT_OFFS, boot);
		axi_rd(pscp_pkg::BOOT_OFFS);
		check("boot_set", rd, boot);
		$display("test registers done");
		// Serial load paused mid-way with the clock stopped
		load_setup(pscp_pkg::MODE_PS, 32'h0000_0010);
		frame(10);
		repeat (300) @(posedge CLK_IN);
		count_is(exp_bits(pscp_pkg::MODE_PS, 10));
		@(negedge CLK_IN);
		check("chain_early", CHAIN_ENABLE_N_OUT, 1'h1);
		frame(6);
		end_pins();
		count_is(exp_bits(pscp_pkg::MODE_PS, 16));
		$display("test serial done");
		// Flash taken by another master, then handed back
		CHAIN_ENABLE_N_IN <= 1'h1;
		load_setup(pscp_pkg::MODE_AP, 32'h0000_0010);
		frame(3);
		count_is(32'h0000_0000);
		CHAIN_ENABLE_N_IN <= 1'h0;
		load_setup(pscp_pkg::MODE_AP, 32'h0000_0010);
		@(negedge CLK_IN);
		check("boot_addr", FLASH_OUT.addr, boot);
		frame(1);
		count_is(exp_bits(pscp_pkg::MODE_AP, 1));
		frame(1);
		end_pins();
		count_is(exp_bits(pscp_pkg::MODE_AP, 2));
		$display("test parallel flash done");
		// Byte-wide load
		load_setup(pscp_pkg::MODE_FPP, 32'h0000_0010);
		frame(2);
		end_pins();
		count_is(exp_bits(pscp_pkg::MODE_FPP, 2));
		// Serial pin handed to user drive in byte mode
		axi_wr(pscp_pkg::CTRL_OFFS, 32'h0000_000a);
		@(negedge CLK_IN);
		check("data0_user", DATA0_OE_OUT, 1'h1);
		$display("test byte load done");
		give_verdict();
	end
endmodule
`default_nettype wire
